/* File: rtl/mrsd_defs.vh */
// Constants for the serial slave command decoder.
`ifndef MRSD_DEFS_VH
`define MRSD_DEFS_VH
`define MRSD_FC_COMPAT 8'h02
`define MRSD_FC_RD_HOLD 8'h03
`define MRSD_FC_RD_INPUT 8'h04
`define MRSD_FC_WR_SINGLE 8'h06
`define MRSD_FC_DIAG 8'h07
`define MRSD_FC_BUSY 8'h0B
`define MRSD_FC_WR_MULTI 8'h10
`define MRSD_FC_PROC_RESET 8'h13
`define MRSD_FC_ESCAPE 8'h7E
`define MRSD_FC_TUNNEL 8'h7F
`define MRSD_ESC_B2 8'hAA
`define MRSD_ESC_B3 8'h55
`define MRSD_EXC_FLAG 8'h80
`define MRSD_EXC_ILL_FUNC 8'h01
`define MRSD_EXC_ILL_ADDR 8'h02
`define MRSD_EXC_ILL_VALUE 8'h03
`define MRSD_BUSY_NO 16'h0000
`define MRSD_BUSY_YES 16'hFFFF
`define MRSD_MAX_READ 16'h0051
`define MRSD_NUM_REGS 16'h0100
`define MRSD_CRC_INIT 16'hFFFF
`define MRSD_CRC_POLY 16'hA001
`define MRSD_CRC_GOOD 16'h0000
`define MRSD_SUB_ECHO 16'h0000
`define MRSD_SUB_RESTART 16'h0001
`define MRSD_SUB_LISTEN 16'h0004
`define MRSD_SUB_CLR_LO 16'h000A
`define MRSD_SUB_CLR_HI 16'h000E
`define MRSD_IDLE_NS 1750
`define MRSD_CLK_NS 5
`define MRSD_IDLE_CYC ((`MRSD_IDLE_NS + `MRSD_CLK_NS - 1) / `MRSD_CLK_NS)
`define MRSD_RX_MAX 256
`endif

/* File: rtl/mrsd_crc16.v */
// Byte-serial CRC-16 accumulator for frame checking.
`timescale 1ns/1ps
`include "mrsd_defs.vh"
module mrsd_crc16 (
    clock,
    rst_q,
    clear,
    step,
    data,
    crc
);
    input wire clock;
    input wire rst_q;
    input wire clear;
    input wire step;
    input wire [7:0] data;
    output reg [15:0] crc;

    // Shifts one byte into the running remainder, low bit first.
    function [15:0] crc_byte;
        input [15:0] c;
        input [7:0] d;
        integer i;
        reg [15:0] t;
        begin
            t = c ^ {8'h00, d};
            for (i = 0; i < 8; i = i + 1) begin
                t = t[0] ? ((t >> 1) ^ `MRSD_CRC_POLY) : (t >> 1);
            end
            crc_byte = t;
        end
    endfunction

    // Restarts at each frame and folds in every received byte.
    always @(posedge clock or negedge rst_q) begin
        if (!rst_q) begin
            crc <= `MRSD_CRC_INIT;
        end else if (clear && step) begin
            // The first byte of a frame is folded into a fresh remainder at once.
            crc <= crc_byte(`MRSD_CRC_INIT, data);
        end else if (clear) begin
            crc <= `MRSD_CRC_INIT;
        end else if (step) begin
            crc <= crc_byte(crc, data);
        end
    end
endmodule // mrsd_crc16

/* File: rtl/mrsd_decoder.v */
// Serial slave command decoder: frame checking, dispatch and reply bytes.
`timescale 1ns/1ps
`include "mrsd_defs.vh"
module mrsd_decoder #(
    parameter NREG = 256,
    parameter IDLE_CYC = `MRSD_IDLE_CYC
) (
    clock,
    rst_b,
    own_addr,
    rx_valid,
    rx_data,
    busy,
    tx_ready,
    tx_valid,
    tx_data,
    tx_last,
    tunnel_valid,
    tunnel_data,
    tunnel_end,
    proc_reset
);
    input wire clock;
    input wire rst_b;
    input wire [7:0] own_addr;
    input wire rx_valid;
    input wire [7:0] rx_data;
    input wire busy;
    input wire tx_ready;
    output reg tx_valid;
    output reg [7:0] tx_data;
    output reg tx_last;
    output reg tunnel_valid;
    output reg [7:0] tunnel_data;
    output reg tunnel_end;
    output reg proc_reset;

    // Dispatch states; the tunnel state streams payload instead of replying.
    localparam S_RX = 2'd0;
    localparam S_EXEC = 2'd1;
    localparam S_TX = 2'd2;
    localparam S_TUN = 2'd3;

    reg rst_m_q;
    reg rst_q;
    reg [1:0] st_q;
    // Receive and reply buffers each hold one whole frame.
    reg [7:0] rxb [0:`MRSD_RX_MAX-1];
    reg [7:0] txb [0:`MRSD_RX_MAX-1];
    // One store serves both the holding and the input view.
    reg [15:0] regs [0:NREG-1];
    reg [8:0] rx_n_q;
    reg [8:0] tx_n_q;
    reg [8:0] tx_i_q;
    reg [15:0] idle_q;
    reg in_frame_q;
    reg ovf_q;
    reg done_q;
    reg escape_q;
    reg [15:0] crc_at_end_q;
    wire [15:0] crc;
    wire crc_clear;
    wire crc_step;
    wire [15:0] busy_word;
    integer k;

    // Two-flop reset release used by all logic below.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_q <= rst_m_q;
        end
    end

    // The remainder restarts on the first byte of every frame and folds in every byte,
    // whatever the dispatcher is doing, so the escape check never depends on it.
    assign crc_clear = rx_valid && !in_frame_q;
    assign crc_step = rx_valid;

    // Status word for the busy query, split into two reply bytes below.
    assign busy_word = busy ? `MRSD_BUSY_YES : `MRSD_BUSY_NO;

    // Running remainder over the frame being collected.
    mrsd_crc16 u_crc (
        .clock(clock),
        .rst_q(rst_q),
        .clear(crc_clear),
        .step(crc_step),
        .data(rx_data),
        .crc(crc)
    );

    // Big-endian 16-bit field from the receive buffer.
    function [15:0] rx16;
        input [8:0] i;
        begin
            rx16 = {rxb[i[7:0]], rxb[i[7:0] + 8'h01]};
        end
    endfunction

    // True when a first..count range lies wholly in the register space.
    function in_range;
        input [15:0] first;
        input [15:0] cnt;
        reg [16:0] endp;
        begin
            endp = {1'b0, first} + {1'b0, cnt};
            in_range = (cnt != 16'h0000) && (endp <= {1'b0, `MRSD_NUM_REGS});
        end
    endfunction

    // Frame collection: an idle gap closes a frame; the next byte starts one.
    always @(posedge clock or negedge rst_q) begin
        if (!rst_q) begin
            rx_n_q <= 9'h000;
            idle_q <= 16'h0000;
            in_frame_q <= 1'b0;
            ovf_q <= 1'b0;
            done_q <= 1'b0;
            escape_q <= 1'b0;
            crc_at_end_q <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            escape_q <= 1'b0;
            if (rx_valid) begin
                idle_q <= 16'h0000;
                in_frame_q <= 1'b1;
                if (!in_frame_q) begin
                    rx_n_q <= 9'h001;
                    ovf_q <= 1'b0;
                    rxb[0] <= rx_data;
                end else if (rx_n_q < `MRSD_RX_MAX) begin
                    rxb[rx_n_q[7:0]] <= rx_data;
                    rx_n_q <= rx_n_q + 9'h001;
                end else begin
                    // Bytes past the buffer end are dropped; the frame is then refused.
                    ovf_q <= 1'b1;
                end
            end else if (in_frame_q) begin
                if (idle_q >= IDLE_CYC[15:0] - 16'h0001) begin
                    in_frame_q <= 1'b0;
                    crc_at_end_q <= crc;
                    // Escape is checked here, ahead of and apart from dispatch.
                    if (!ovf_q && rx_n_q == 9'd6 && rxb[0] == own_addr
                            && rxb[1] == `MRSD_FC_ESCAPE && rxb[2] == `MRSD_ESC_B2
                            && rxb[3] == `MRSD_ESC_B3 && crc == `MRSD_CRC_GOOD) begin
                        escape_q <= 1'b1;
                    end else begin
                        done_q <= 1'b1;
                    end
                end else begin
                    idle_q <= idle_q + 16'h0001;
                end
            end
        end
    end

    // Dispatch, register access, reply building and transmission.
    always @(posedge clock or negedge rst_q) begin
        if (!rst_q) begin
            st_q <= S_RX;
            tx_n_q <= 9'h000;
            tx_i_q <= 9'h000;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
            tunnel_valid <= 1'b0;
            tunnel_data <= 8'h00;
            tunnel_end <= 1'b0;
            proc_reset <= 1'b0;
            for (k = 0; k < NREG; k = k + 1) begin
                regs[k] <= 16'h0000;
            end
        end else begin
            proc_reset <= escape_q;
            tunnel_valid <= 1'b0;
            tunnel_end <= 1'b0;
            case (st_q)
                S_RX: begin
                    // Only a clean, addressed frame leads to any reply.
                    if (done_q && !ovf_q && rx_n_q >= 9'd4 && crc_at_end_q == `MRSD_CRC_GOOD
                            && rxb[0] == own_addr) begin
                        st_q <= S_EXEC;
                        tx_i_q <= 9'h000;
                    end
                end
                S_EXEC: begin
                    // Reply header is common to all codes; each branch fills in the rest.
                    txb[0] <= own_addr;
                    txb[1] <= rxb[1];
                    tx_n_q <= 9'h000;
                    st_q <= S_TX;
                    case (rxb[1])
                        `MRSD_FC_COMPAT, `MRSD_FC_RD_HOLD, `MRSD_FC_RD_INPUT: begin
                            // An oversize or out-of-range read is refused and reads nothing.
                            if (rx16(9'd4) > `MRSD_MAX_READ
                                    || !in_range(rx16(9'd2), rx16(9'd4))) begin
                                txb[1] <= rxb[1] | `MRSD_EXC_FLAG;
                                txb[2] <= `MRSD_EXC_ILL_ADDR;
                                tx_n_q <= 9'd3;
                            end else begin
                                txb[2] <= {rxb[5][6:0], 1'b0};
                                for (k = 0; k < 81; k = k + 1) begin
                                    txb[3 + 2 * k] <= regs[(rx16(9'd2) + k) % NREG][15:8];
                                    txb[4 + 2 * k] <= regs[(rx16(9'd2) + k) % NREG][7:0];
                                end
                                tx_n_q <= 9'd3 + {rxb[5], 1'b0};
                            end
                        end
                        `MRSD_FC_WR_SINGLE: begin
                            // Reserved registers are not guarded; the master keeps off them.
                            if (!in_range(rx16(9'd2), 16'h0001)) begin
                                txb[1] <= rxb[1] | `MRSD_EXC_FLAG;
                                txb[2] <= `MRSD_EXC_ILL_ADDR;
                                tx_n_q <= 9'd3;
                            end else begin
                                regs[rx16(9'd2) % NREG] <= rx16(9'd4);
                                for (k = 2; k < 6; k = k + 1) begin
                                    txb[k] <= rxb[k];
                                end
                                tx_n_q <= 9'd6;
                            end
                        end
                        `MRSD_FC_WR_MULTI: begin
                            // The byte count must match twice the register count and the
                            // frame length, so no register is loaded from stale buffer bytes.
                            if (!in_range(rx16(9'd2), rx16(9'd4))
                                    || rxb[4] != 8'h00 || rxb[5][7]
                                    || rxb[6] != {rxb[5][6:0], 1'b0}
                                    || rx_n_q != 9'd9 + {1'b0, rxb[6]}) begin
                                txb[1] <= rxb[1] | `MRSD_EXC_FLAG;
                                txb[2] <= `MRSD_EXC_ILL_VALUE;
                                tx_n_q <= 9'd3;
                            end else begin
                                // Only the first count words are stored; later passes idle.
                                for (k = 0; k < 123; k = k + 1) begin
                                    if (k < rx16(9'd4)) begin
                                        regs[(rx16(9'd2) + k) % NREG] <=
                                            {rxb[7 + 2 * k], rxb[8 + 2 * k]};
                                    end
                                end
                                for (k = 2; k < 6; k = k + 1) begin
                                    txb[k] <= rxb[k];
                                end
                                tx_n_q <= 9'd6;
                            end
                        end
                        `MRSD_FC_DIAG: begin
                            // Supported sub-functions echo the request; no counters are kept.
                            if (rx16(9'd2) == `MRSD_SUB_RESTART || rx16(9'd2) == `MRSD_SUB_LISTEN
                                    || (rx16(9'd2) >= `MRSD_SUB_CLR_LO
                                    && rx16(9'd2) <= `MRSD_SUB_CLR_HI)) begin
                                for (k = 2; k < 6; k = k + 1) begin
                                    txb[k] <= rxb[k];
                                end
                                tx_n_q <= 9'd6;
                            end else begin
                                txb[1] <= rxb[1] | `MRSD_EXC_FLAG;
                                txb[2] <= `MRSD_EXC_ILL_VALUE;
                                tx_n_q <= 9'd3;
                            end
                        end
                        `MRSD_FC_BUSY: begin
                            // Status word goes out high byte first.
                            txb[2] <= busy_word[15:8];
                            txb[3] <= busy_word[7:0];
                            tx_n_q <= 9'd4;
                        end
                        `MRSD_FC_PROC_RESET: begin
                            // No reply is sent: the processor restarts on this pulse.
                            proc_reset <= 1'b1;
                            st_q <= S_RX;
                        end
                        `MRSD_FC_TUNNEL: begin
                            // Payload bytes stream out one per cycle below.
                            tx_i_q <= 9'd2;
                            st_q <= S_TUN;
                        end
                        default: begin
                            // Any code not decoded above gets an illegal-function exception.
                            txb[1] <= rxb[1] | `MRSD_EXC_FLAG;
                            txb[2] <= `MRSD_EXC_ILL_FUNC;
                            tx_n_q <= 9'd3;
                        end
                    endcase
                end
                S_TX: begin
                    // Sends the reply; the two CRC bytes are appended outside.
                    if (!tx_valid || tx_ready) begin
                        if (tx_i_q < tx_n_q) begin
                            tx_valid <= 1'b1;
                            tx_data <= txb[tx_i_q[7:0]];
                            tx_last <= (tx_i_q == tx_n_q - 9'h001);
                            tx_i_q <= tx_i_q + 9'h001;
                        end else begin
                            tx_valid <= 1'b0;
                            tx_last <= 1'b0;
                            st_q <= S_RX;
                        end
                    end
                end
                S_TUN: begin
                    // Address, code and CRC bytes are stripped; the native handler
                    // takes one byte per cycle and cannot stall the stream.
                    if (tx_i_q + 9'd2 < rx_n_q) begin
                        tunnel_valid <= 1'b1;
                        tunnel_data <= rxb[tx_i_q[7:0]];
                        tunnel_end <= (tx_i_q + 9'd3 == rx_n_q);
                        tx_i_q <= tx_i_q + 9'h001;
                    end else begin
                        st_q <= S_RX;
                    end
                end
                default: begin
                    // No other state code exists; fall back to waiting for a frame.
                    st_q <= S_RX;
                end
            endcase
        end
    end
endmodule // mrsd_decoder

/* File: testbench/mrsd_decoder_props.sv */
// Port assertions for the serial slave command decoder.
`timescale 1ns/1ps
module mrsd_decoder_props #(
    parameter IDLE_CYC = 8
) (
    input wire clock,
    input wire rst_b,
    input wire [7:0] own_addr,
    input wire rx_valid,
    input wire tx_ready,
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_last,
    input wire tunnel_valid,
    input wire tunnel_end,
    input wire proc_reset
);
    reg [9:0] gap_q;
    reg rx_seen_q;
    reg in_reply_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Quiet cycles on the receive side, pending request and reply progress.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gap_q <= 10'h000;
            rx_seen_q <= 1'b0;
            in_reply_q <= 1'b0;
        end else begin
            gap_q <= rx_valid ? 10'h000 : gap_q + {9'h000, gap_q != 10'h3FF};
            if (rx_valid)
                rx_seen_q <= 1'b1;
            else if (tx_valid && tx_ready && tx_last)
                rx_seen_q <= 1'b0;
            if (tx_valid && tx_ready)
                in_reply_q <= !tx_last;
        end
    end
    slave_only_a: assert property (tx_valid |-> rx_seen_q)
        else $error("Reply offered with no request pending.");
    lead_addr_a: assert property (tx_valid && !in_reply_q |-> tx_data == own_addr)
        else $error("Reply does not start with the own address.");
    byte_hold_a: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("Reply byte changed before it was taken.");
    last_qual_a: assert property (tx_last |-> tx_valid)
        else $error("Last marker without a valid byte.");
    reboot_gap_a: assert property (proc_reset |->
        gap_q >= IDLE_CYC && gap_q <= IDLE_CYC + 8)
        else $error("Reboot pulse not tied to the end of a frame.");
    reboot_pulse_a: assert property (proc_reset |=> !proc_reset)
        else $error("Reboot pulse longer than one cycle.");
    reboot_quiet_a: assert property (proc_reset |-> !tx_valid)
        else $error("Reboot pulse while replying.");
    tunnel_end_a: assert property (tunnel_end |-> tunnel_valid)
        else $error("Tunnel end without a tunnel byte.");
    tunnel_gap_a: assert property (tunnel_valid |-> gap_q >= IDLE_CYC)
        else $error("Tunnel byte passed before the frame ended.");
endmodule // mrsd_decoder_props

bind mrsd_decoder mrsd_decoder_props #(.IDLE_CYC(IDLE_CYC)) props_u (.clock(clock),
    .rst_b(rst_b), .own_addr(own_addr), .rx_valid(rx_valid), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tunnel_valid(tunnel_valid),
    .tunnel_end(tunnel_end), .proc_reset(proc_reset));

/* File: testbench/mrsd_master.sv */
// Polling bus master model: sends request frames and takes reply bytes.
`timescale 1ns/1ps
module mrsd_master (
    input wire clock,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic tx_ready,
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_last
);
    logic [7:0] rsp[$];
    int replies = 0;
    // Lines idle at time zero.
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
    end
    // Reflected CRC-16 over a byte queue.
    function automatic logic [15:0] crc16(input logic [7:0] f[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (f[i]) begin
            c = c ^ {8'h00, f[i]};
            for (int b = 0; b < 8; b++)
                c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    // Send a frame with a quiet cycle between bytes; bad corrupts the CRC.
    task automatic send(input logic [7:0] f[$], input logic bad);
        logic [15:0] c;
        c = crc16(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            @(negedge clock);
            rx_valid = 1'b1;
            rx_data = f[i];
            @(negedge clock);
            rx_valid = 1'b0;
            rx_data = ~f[i]; // A released data line keeps no stale value.
        end
    endtask
    // Random stalls on the reply side.
    always @(negedge clock)
        tx_ready <= ($urandom % 4) != 0;
    // Take a reply byte when both sides agree.
    always @(posedge clock)
        if (tx_valid && tx_ready) begin
            rsp.push_back(tx_data);
            if (tx_last)
                replies <= replies + 1;
        end
endmodule // mrsd_master

/* File: testbench/test_modbus_rtu_slave_command_decoder.sv */
// Self-checking bench for the serial slave command decoder.
`timescale 1ns/1ps
`include "mrsd_defs.vh"
module test_modbus_rtu_slave_command_decoder;
    typedef logic [7:0] mrsd_bytes_t[$];
    localparam int IDLE = 8;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] own_addr = 8'h11;
    logic busy = 1'b0;
    wire rx_valid, tx_ready, tx_valid, tx_last, tunnel_valid, tunnel_end, proc_reset;
    wire [7:0] rx_data, tx_data, tunnel_data;
    int bad_count = 0;
    int check_count = 0;
    int resets = 0;
    int tend_at = 0;
    int sub[9] = '{1, 4, 10, 11, 12, 13, 14, 2, 15};
    logic [7:0] rd[3] = '{`MRSD_FC_COMPAT, `MRSD_FC_RD_HOLD, `MRSD_FC_RD_INPUT};
    logic [15:0] mem[256];
    logic [15:0] a, v;
    mrsd_bytes_t f, tun;
    mrsd_decoder #(.IDLE_CYC(IDLE)) dut_u (.clock(clock), .rst_b(rst_b), .own_addr(own_addr),
        .rx_valid(rx_valid), .rx_data(rx_data), .busy(busy), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tunnel_valid(tunnel_valid),
        .tunnel_data(tunnel_data), .tunnel_end(tunnel_end), .proc_reset(proc_reset));
    mrsd_master m_u (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last));
    // Clock toggles every half period.
    always #2.5 clock = ~clock;
    // Collect tunnel bytes and count reboot pulses.
    always @(posedge clock) begin
        if (tunnel_valid)
            tun.push_back(tunnel_data);
        if (tunnel_valid && tunnel_end)
            tend_at = tun.size();
        if (proc_reset)
            resets++;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_q(input mrsd_bytes_t g, input mrsd_bytes_t x);
        check(g.size(), x.size());
        foreach (x[i])
            check(g[i], x[i]);
    endtask
    function automatic mrsd_bytes_t fr(input logic [7:0] fc, input logic [15:0] p, q);
        return {own_addr, fc, p[15:8], p[7:0], q[15:8], q[7:0]};
    endfunction
    function automatic mrsd_bytes_t exc(input logic [7:0] fc, input logic [7:0] code);
        return {own_addr, fc | `MRSD_EXC_FLAG, code};
    endfunction
    function automatic mrsd_bytes_t exp_read(input logic [7:0] fc, input int s, input int n);
        mrsd_bytes_t r;
        r = {own_addr, fc, 8'(2 * n)};
        for (int i = s; i < s + n; i++)
            r = {r, mem[i][15:8], mem[i][7:0]};
        return r;
    endfunction
    // Send a request, wait a bounded time for a reply if one is due, then let the line idle.
    task automatic xfer(input mrsd_bytes_t fq, input logic bad, input logic want);
        int n;
        n = m_u.replies;
        m_u.rsp.delete();
        m_u.send(fq, bad);
        for (int k = 0; k < 3000 && want && m_u.replies == n; k++)
            @(posedge clock);
        repeat (IDLE + 40) @(posedge clock);
        if (want)
            check(m_u.replies - n, 1);
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog cuts a hang short.
    initial begin
        #400000;
        bad_count++;
        end_sim();
    end
    // Main sequence.
    initial begin
        void'($urandom(32'h36FE));
        foreach (mem[i])
            mem[i] = 16'h0000;
        own_addr = 8'h01 + 8'($urandom % 200);
        repeat (20) @(negedge clock);
        rst_b = 1'b1;
        repeat (IDLE + 4) @(negedge clock);
        for (int k = 0; k < 5; k++) begin
            a = (k == 0) ? 16'h0000 : (k == 1) ? 16'h00FF : 16'($urandom % 256);
            v = 16'($urandom);
            mem[a] = v;
            xfer(fr(`MRSD_FC_WR_SINGLE, a, v), 1'b0, 1'b1);
            check_q(m_u.rsp, fr(`MRSD_FC_WR_SINGLE, a, v));
            foreach (rd[j]) begin
                xfer(fr(rd[j], a, 16'h0001), 1'b0, 1'b1);
                check_q(m_u.rsp, exp_read(rd[j], a, 1));
            end
        end
        $display("test 1 done");
        xfer(fr(`MRSD_FC_RD_HOLD, 16'h00AF, 16'h0051), 1'b0, 1'b1);
        check_q(m_u.rsp, exp_read(`MRSD_FC_RD_HOLD, 175, 81));
        xfer(fr(`MRSD_FC_RD_INPUT, 16'h0000, 16'h0052), 1'b0, 1'b1);
        check_q(m_u.rsp, exc(`MRSD_FC_RD_INPUT, `MRSD_EXC_ILL_ADDR));
        a = 16'($urandom % 250);
        f = {fr(`MRSD_FC_WR_MULTI, a, 16'h0003), 8'h06};
        for (int i = 0; i < 3; i++) begin
            v = 16'($urandom);
            mem[a + i] = v;
            f = {f, v[15:8], v[7:0]};
        end
        xfer(f, 1'b0, 1'b1);
        check_q(m_u.rsp, fr(`MRSD_FC_WR_MULTI, a, 16'h0003));
        xfer(fr(`MRSD_FC_RD_HOLD, a, 16'h0003), 1'b0, 1'b1);
        check_q(m_u.rsp, exp_read(`MRSD_FC_RD_HOLD, a, 3));
        $display("test 2 done");
        foreach (sub[j]) begin
            f = fr(`MRSD_FC_DIAG, 16'(sub[j]), 16'($urandom));
            xfer(f, 1'b0, 1'b1);
            check_q(m_u.rsp, j > 6 ? exc(`MRSD_FC_DIAG, `MRSD_EXC_ILL_VALUE) : f);
        end
        for (int b = 0; b < 2; b++) begin
            @(negedge clock);
            busy = b[0];
            xfer({own_addr, `MRSD_FC_BUSY}, 1'b0, 1'b1);
            check({m_u.rsp[2], m_u.rsp[3]}, b ? `MRSD_BUSY_YES : `MRSD_BUSY_NO);
        end
        $display("test 3 done");
        xfer(fr(8'h05, 16'h0000, 16'h0001), 1'b0, 1'b1);
        check_q(m_u.rsp, exc(8'h05, `MRSD_EXC_ILL_FUNC));
        f = fr(`MRSD_FC_RD_HOLD, 16'h0000, 16'h0001);
        xfer(f, 1'b1, 1'b0);
        check(m_u.rsp.size(), 0);
        f[0] = own_addr + 8'h01;
        xfer(f, 1'b0, 1'b0);
        check(m_u.rsp.size(), 0);
        f = {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
        tun.delete();
        tend_at = 0;
        xfer({own_addr, `MRSD_FC_TUNNEL, f}, 1'b0, 1'b0);
        check_q(tun, f);
        check(tend_at, f.size());
        $display("test 4 done");
        xfer({own_addr, `MRSD_FC_ESCAPE, `MRSD_ESC_B2, `MRSD_ESC_B3}, 1'b1, 1'b0);
        xfer({own_addr, `MRSD_FC_ESCAPE, `MRSD_ESC_B2}, 1'b0, 1'b0);
        check(resets, 0);
        xfer({own_addr, `MRSD_FC_ESCAPE, `MRSD_ESC_B2, `MRSD_ESC_B3}, 1'b0, 1'b0);
        check(resets, 1);
        xfer({own_addr, `MRSD_FC_PROC_RESET}, 1'b0, 1'b0);
        check(resets, 2);
        check(m_u.rsp.size(), 0);
        $display("test 5 done");
        end_sim();
    end
endmodule // test_modbus_rtu_slave_command_decoder
